/* rtl/sih_pkg.sv */
// shared constants and types for the serialized interrupt host
package sih_pkg;

  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,  // no cycle on the line
    ST_START    = 6'h02,  // host drives the start frame low
    ST_START_HI = 6'h04,  // one high clock that ends the start frame
    ST_DATA     = 6'h08,  // data frames, three phases each
    ST_STOP     = 6'h10,  // host drives the stop frame low
    ST_STOP_HI  = 6'h20   // one high clock that ends the stop frame
  } sih_state_t;

  // frame layout
  localparam int          NUM_FRAMES = 17;    // data frames per cycle
  localparam int          FRM_W      = 5;     // width of the frame counter
  localparam logic [1:0]  PH_SAMPLE  = 2'h0;  // sample phase
  localparam logic [1:0]  PH_RECOVER = 2'h1;  // recovery phase
  localparam logic [1:0]  PH_TURN    = 2'h2;  // turn-around phase

  // start frame hold, further clocks after the first low one
  localparam logic [2:0]  START_HOLD_MIN = 3'h3;
  // stop frame low counts, the count chooses the next mode
  localparam logic [2:0]  STOP_LOW_QUIET = 3'h2;
  localparam logic [2:0]  STOP_LOW_CONT  = 3'h3;

  // line input synchroniser depth and the matching sample delay
  localparam int          SYNC_LAT   = 3;
  // idle clocks before the line is watched again, covers the synchroniser
  localparam logic [2:0]  IDLE_GUARD = 3'h4;

  // frame position to interrupt number, the marked slot is the sysmgmt frame
  localparam int          NUM_IRQ  = 16;
  localparam logic [4:0]  SLOT_SYSMGMT = 5'h1F;
  localparam logic [4:0]  SLOT_IRQ [0:NUM_FRAMES-1] = '{
    5'h00, 5'h01, 5'h02, 5'h1F, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F
  };
  localparam logic [FRM_W-1:0] SYSMGMT_FRAME = 5'h03;  // frame that carries the request

endpackage

/* rtl/sih_sync.sv */
// three-stage synchroniser for the shared interrupt line
`timescale 1ns/10ps
module sih_sync
  import sih_pkg::*;
#(
  parameter int STAGES = SYNC_LAT
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pin and synchronised level
  input  wire logic d,
  output logic      q
);

  logic [STAGES-1:0] sh_r;  // shift chain, bit 0 is the first stage

  // the line idles high through its pull-up, so reset to high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sh_r <= '1;
    else
      sh_r <= {sh_r[STAGES-2:0], d};
  end

  // only the last stage leaves the module
  assign q = sh_r[STAGES-1];

endmodule // sih_sync

/* rtl/sih_host.sv */
// host end of the single-wire serialized interrupt link
// Summary of operation
// - cycle is start, data frames, one stop
// - host supports quiet and continuous modes
// - that low pulse moves host out of idle
// - host then holds line low 3-7 more clocks
// - after start low, one high clock, then release
// - continuous mode: host starts cycle, 4-8 low clocks
// - reset enters continuous mode
// - frames counted from start frame rising edge
// - data frame is sample, recovery, turn-around
// - nobody drives during recovery or turn-around
// - raw sampled level goes to interrupt controller
// - low in frame 3 asserts sysmgmt request
`timescale 1ns/10ps
module sih_host
  import sih_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // shared open-drain line
  input  wire logic               line_in,
  output logic                    line_out,
  output logic                    line_oe,
  // mode and timing control
  input  wire logic               quiet_req,
  input  wire logic [2:0]         start_len,
  // results
  output logic [NUM_IRQ-1:0]      irq_level,
  output logic                    external_sysmgmt_request_n,
  output logic                    quiet_mode,
  output logic                    cycle_done
);

  sih_state_t                     state_r;       // controller state
  sih_state_t                     state_nxt;     // its next value
  logic [2:0]                     cnt_r;         // low-clock countdown
  logic [2:0]                     cnt_nxt;
  logic [1:0]                     ph_r;          // data frame phase
  logic [1:0]                     ph_nxt;
  logic [FRM_W-1:0]               frame_r;       // data frame number
  logic [FRM_W-1:0]               frame_nxt;
  logic [2:0]                     guard_r;       // idle guard countdown
  logic                           quiet_r;       // current mode, 1 = quiet
  logic                           next_quiet_r;  // mode chosen for next cycle
  logic                           line_s;        // synchronised line level
  logic [2:0]                     hold_len;      // clamped start hold
  logic [SYNC_LAT-1:0]            smp_v_r;       // sample strobe delay line
  logic [SYNC_LAT-1:0][FRM_W-1:0] smp_f_r;       // frame number delay line
  logic [4:0]                     slot;          // slot of the delayed sample
  logic                           out_r;         // line drive value
  logic                           oe_r;          // line drive enable
  logic [NUM_IRQ-1:0]             irq_level_r;   // sampled raw levels
  logic                           sysmgmt_n_r;   // sysmgmt request, low active
  logic                           done_r;        // end-of-cycle pulse

  // line synchroniser, its delay is matched by the sample delay line
  sih_sync #(.STAGES (SYNC_LAT)) u_sync (.clk (clk), .rst_n (rst_n), .d (line_in), .q (line_s));

  // values below the hold minimum would make a start frame too short
  assign hold_len = (start_len < START_HOLD_MIN) ? START_HOLD_MIN : start_len;

  // next-state logic for the cycle sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ph_nxt    = ph_r;
    frame_nxt = frame_r;
    unique case (state_r)
      ST_IDLE:
      begin
        // guard keeps the tail of our own stop frame from looking like a request
        if (guard_r == 3'h0 && !quiet_r)
        begin
          // continuous mode: start unprompted, hold+1 low clocks
          state_nxt = ST_START;
          cnt_nxt   = hold_len;
        end
        else if (guard_r == 3'h0 && !line_s)
        begin
          // a peripheral already gave the first low clock
          state_nxt = ST_START;
          cnt_nxt   = hold_len - 3'h1;
        end
      end
      ST_START:
      begin
        // count down the low clocks of the start frame
        if (cnt_r == 3'h0)
          state_nxt = ST_START_HI;
        else
          cnt_nxt = cnt_r - 3'h1;
      end
      ST_START_HI:
      begin
        // rising edge just made, frame zero follows
        state_nxt = ST_DATA;
        ph_nxt    = PH_SAMPLE;
        frame_nxt = '0;
      end
      ST_DATA:
      begin
        // three phases per frame, then next frame or the stop frame
        if (ph_r == PH_TURN)
        begin
          ph_nxt = PH_SAMPLE;
          if (frame_r == FRM_W'(NUM_FRAMES - 1))
          begin
            state_nxt = ST_STOP;
            cnt_nxt   = quiet_req ? (STOP_LOW_QUIET - 3'h1)
                                  : (STOP_LOW_CONT - 3'h1);
          end
          else
            frame_nxt = frame_r + FRM_W'(1);
        end
        else
          ph_nxt = ph_r + 2'h1;
      end
      ST_STOP:
      begin
        // low part of the stop frame
        if (cnt_r == 3'h0)
          state_nxt = ST_STOP_HI;
        else
          cnt_nxt = cnt_r - 3'h1;
      end
      // one high clock, then the line is released
      ST_STOP_HI: state_nxt = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 3'h0;
      ph_r    <= PH_SAMPLE;
      frame_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ph_r    <= ph_nxt;
      frame_r <= frame_nxt;
    end
  end

  // idle guard, reloaded as each cycle ends
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      guard_r <= 3'h0;
    else if (state_r == ST_STOP_HI)
      guard_r <= IDLE_GUARD;
    else if (guard_r != 3'h0)
      guard_r <= guard_r - 3'h1;
  end

  // mode: continuous after reset, stop frame length switches it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      quiet_r      <= 1'b0;
      next_quiet_r <= 1'b0;
    end
    // the two updates fall in different states, so one chain serves both
    else if (state_r == ST_STOP_HI)
      quiet_r <= next_quiet_r;
    else if (state_r == ST_DATA && state_nxt == ST_STOP)
      next_quiet_r <= quiet_req;
  end

  // pin drive follows the next state so the pin is registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_r <= 1'b1;
      oe_r  <= 1'b0;
    end
    else
    begin
      // low in start and stop frames, high in their closing clocks
      out_r <= !(state_nxt inside {ST_START, ST_STOP});
      // idle and all data phases: hands off the line
      oe_r  <= !(state_nxt inside {ST_IDLE, ST_DATA});
    end
  end

  // sample strobe delayed to meet the synchronised level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      smp_v_r <= '0;
      smp_f_r <= '0;
    end
    else
    begin
      smp_v_r <= {smp_v_r[SYNC_LAT-2:0], (state_r == ST_DATA && ph_r == PH_SAMPLE)};
      smp_f_r <= {smp_f_r[SYNC_LAT-2:0], frame_r};
    end
  end

  assign slot = SLOT_IRQ[smp_f_r[SYNC_LAT-1]];

  // raw levels and the sysmgmt request; the controller judges polarity
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_level_r <= '1;
      sysmgmt_n_r <= 1'b1;
    end
    else if (smp_v_r[SYNC_LAT-1])
    begin
      if (slot != SLOT_SYSMGMT)
        irq_level_r[slot[3:0]] <= line_s;
      else
        sysmgmt_n_r <= line_s;
    end
  end

  // one-clock pulse once a whole cycle has been sampled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else
      done_r <= (state_r == ST_STOP_HI);
  end

  assign line_out                   = out_r;
  assign line_oe                    = oe_r;
  assign irq_level                  = irq_level_r;
  assign external_sysmgmt_request_n = sysmgmt_n_r;
  assign quiet_mode                 = quiet_r;
  assign cycle_done                 = done_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_cont;
    $rose(rst_n) |-> !quiet_r;
  endproperty
  a_reset_cont: assert property (p_reset_cont) else $error("not continuous after reset");
  property p_quiet_wait;
    (state_r == ST_IDLE && quiet_r && line_s) |=> (state_r == ST_IDLE);
  endproperty
  a_quiet_wait: assert property (p_quiet_wait) else $error("quiet start without request");
  property p_quiet_start;
    (state_r == ST_IDLE && quiet_r && guard_r == 3'h0 && !line_s)
      |=> (line_oe && !line_out) [*3];
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("quiet start too short");
  property p_cont_start;
    (state_r == ST_IDLE && !quiet_r && guard_r == 3'h0) |=> (line_oe && !line_out) [*4];
  endproperty
  a_cont_start: assert property (p_cont_start) else $error("continuous start too short");
  property p_start_end;
    (state_r == ST_START && cnt_r == 3'h0) |=> (line_oe && line_out) ##1 !line_oe;
  endproperty
  a_start_end: assert property (p_start_end) else $error("start frame end wrong");
  property p_frame_phases;
    (state_r == ST_START_HI) |=> (frame_r == '0 && ph_r == PH_SAMPLE)
      ##1 (ph_r == PH_RECOVER) ##1 (ph_r == PH_TURN) ##1 (ph_r == PH_SAMPLE);
  endproperty
  a_frame_phases: assert property (p_frame_phases) else $error("data frame not three clocks");
  property p_data_quiet;
    (state_r == ST_DATA) |-> !line_oe;
  endproperty
  a_data_quiet: assert property (p_data_quiet) else $error("host drives in data frame");
  property p_raw_level;
    (smp_v_r[SYNC_LAT-1] && slot != SLOT_SYSMGMT)
      |=> (irq_level_r[$past(slot[3:0])] == $past(line_s));
  endproperty
  a_raw_level: assert property (p_raw_level) else $error("sampled level not delivered");
  property p_sysmgmt;
    (smp_v_r[SYNC_LAT-1] && smp_f_r[SYNC_LAT-1] == SYSMGMT_FRAME && !line_s)
      |=> !external_sysmgmt_request_n;
  endproperty
  a_sysmgmt: assert property (p_sysmgmt) else $error("sysmgmt request missed");
  property p_stop_cont;
    (state_r == ST_DATA && state_nxt == ST_STOP && !quiet_req)
      |=> (line_oe && !line_out) [*3] ##1 (line_oe && line_out) ##1 !line_oe;
  endproperty
  a_stop_cont: assert property (p_stop_cont) else $error("stop frame shape wrong");

endmodule // sih_host

/* verif/sih_periph.sv */
// behavioural peripheral group sharing the serialized interrupt line
`timescale 1ns/10ps
module sih_periph (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // line level and controls
  input  wire logic        line,
  input  wire logic [16:0] frame_lvl,  // level shown per frame, 0 pulls low
  input  wire logic        kick,       // ask for a quiet-mode start
  // pull-down, 1 pulls the line low
  output logic             pull
);
  logic [3:0] low_r;   // low clocks seen in a row
  logic       act_r;   // counting data frames
  logic [1:0] ph_r;    // phase in frame
  logic [4:0] frm_r;   // frame number
  logic       kick_r;  // one-clock start pulse

  // frame tracking; a long low ending in a rising edge starts counting,
  // short stop lows stay below the threshold
  always_ff @(posedge clk)
  begin
    kick_r <= rst_n & kick & ~act_r;
    low_r  <= line ? 4'h0 : (low_r == 4'hF ? low_r : low_r + 4'h1);
    if (!rst_n)
    begin
      act_r <= 1'b0;
      ph_r  <= 2'h0;
      frm_r <= 5'h00;
    end
    else if (line && low_r >= 4'h4)
    begin
      act_r <= 1'b1;
      ph_r  <= 2'h0;
      frm_r <= 5'h00;
    end
    else if (act_r)
    begin
      ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      if (ph_r == 2'h2)
        frm_r <= frm_r + 5'h01;
      if (ph_r == 2'h2 && frm_r == 5'h10)
        act_r <= 1'b0;
    end
  end

  // frame pulls only in the sample phase, kick_r pulls while not counting; recovery and turn stay released
  assign pull = kick_r | (act_r & (ph_r == 2'h0) & ~frame_lvl[frm_r]);
endmodule  // sih_periph

/* verif/serial_interrupt_host_tb.sv */
// self-checking bench for the serialized interrupt host
`timescale 1ns/10ps
module serial_interrupt_host_tb;
  import sih_pkg::*;
  logic               clk       = 1'b0;      // 250 MHz
  logic               rst_n     = 1'b0;      // synchronous reset
  logic               quiet_req = 1'b1;      // mode for next cycle
  logic [2:0]         start_len = 3'h3;      // start hold count
  logic [16:0]        frame_lvl = 17'h1A5F2; // frame levels, frame 3 low
  logic               kick      = 1'b0;      // peripheral start request
  logic               line_out;
  logic               line_oe;
  logic               quiet_mode;
  logic               cycle_done;
  logic               external_sysmgmt_request_n;
  logic               pull;
  logic               line;
  logic [NUM_IRQ-1:0] irq_level;
  int                 miscompares = 0;
  int                 cmp_count   = 0;
  int                 wait_n;                // clocks until host drove low

  // wired-AND of both drivers with the pull-up
  assign line = ~(line_oe & ~line_out) & ~pull;
  always #2 clk = ~clk;

  sih_host dut (.clk(clk), .rst_n(rst_n), .line_in(line), .line_out(line_out),
    .line_oe(line_oe), .quiet_req(quiet_req), .start_len(start_len),
    .irq_level(irq_level), .external_sysmgmt_request_n(external_sysmgmt_request_n),
    .quiet_mode(quiet_mode), .cycle_done(cycle_done));
  sih_periph periph (.clk(clk), .rst_n(rst_n), .line(line), .frame_lvl(frame_lvl),
    .kick(kick), .pull(pull));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // expected levels through the slot table; unmapped numbers stay high
  function automatic logic [15:0] exp_irq(logic [16:0] lvl);
    logic [15:0] e;
    e = 16'hFFFF;
    for (int f = 0; f < NUM_FRAMES; f++)
      if (SLOT_IRQ[f] != SLOT_SYSMGMT)
        e[SLOT_IRQ[f][3:0]] = lvl[f];
    return e;
  endfunction

  // counts clocks of host low drive, sampled at falling edges
  task automatic count_low(output int n);
    n = 0;
    while (line_oe === 1'b1 && line_out === 1'b0 && n < 20)
    begin
      n++;
      @(negedge clk);
    end
  endtask

  // follows one whole cycle on the line and judges its shape and results
  task automatic watch(int n_low, int n_stop, logic q_next);
    int n;
    wait_n = 0;
    while (!(line_oe === 1'b1 && line_out === 1'b0) && wait_n < 200)
    begin
      @(negedge clk);
      wait_n++;
    end
    count_low(n);
    check("start low", 16'(n), 16'(n_low));
    check("start high", {14'h0, line_oe, line_out}, 16'h3);
    @(negedge clk);
    n = 0;
    while (line_oe === 1'b0 && n < 60)
    begin
      n++;
      @(negedge clk);
    end
    check("data clocks", 16'(n), 16'h33);
    count_low(n);
    check("stop low", 16'(n), 16'(n_stop));
    check("stop high", {14'h0, line_oe, line_out}, 16'h3);
    @(negedge clk);
    check("cycle done", {15'h0, cycle_done}, 16'h1);
    check("quiet mode", {15'h0, quiet_mode}, {15'h0, q_next});
    check("irq level", irq_level, exp_irq(frame_lvl));
    check("sysmgmt", {15'h0, external_sysmgmt_request_n}, {15'h0, frame_lvl[3]});
  endtask

  // reset values, then a continuous cycle at once that asks for quiet mode
  task automatic s_reset();
    repeat (16) @(negedge clk);
    check("rst drive", {14'h0, line_oe, line_out}, 16'h1);
    check("rst irq", irq_level, 16'hFFFF);
    check("rst mode", {14'h0, quiet_mode, external_sysmgmt_request_n}, 16'h1);
    rst_n = 1'b1;
    watch(4, 2, 1'b1);
    check("start after reset", 16'(wait_n), 16'h1);
  endtask

  // quiet mode: host stays idle until a peripheral pulse, longest hold
  task automatic s_quiet();
    int n;
    start_len = 3'h7;
    quiet_req = 1'b0;
    frame_lvl = 17'h0C3D8;
    n = 0;
    repeat (30)
    begin
      @(negedge clk);
      n += int'(line_oe !== 1'b0);
    end
    check("quiet idle", 16'(n), 16'h0);
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
    watch(7, 3, 1'b0);
    check("quiet start delay", 16'(wait_n), 16'h4);
  endtask

  // continuous again, start count below range acts as the minimum
  task automatic s_back_to_back();
    start_len = 3'h1;
    frame_lvl = 17'h00000;
    watch(4, 3, 1'b0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // the three cycles take a few hundred clocks; this is ample
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    s_reset();
    s_quiet();
    s_back_to_back();
    end_of_test();
  end
endmodule  // serial_interrupt_host_tb
